// File: pkg/rpd_pkg.sv
// Purpose: Shared constants for the reprogramming delay and query block
// Assumes: 10 MHz hclk, 32-bit AHB-Lite register access
// Notes:   Offsets are byte addresses; each register is one aligned word
package rpd_pkg;
  // Register offsets
  localparam logic [7:0] OFS_DISPLAY = 8'h00;
  localparam logic [7:0] OFS_CALMODE = 8'h04;
  localparam logic [7:0] OFS_PWRUP   = 8'h08;
  localparam logic [7:0] OFS_DLYSET  = 8'h0c;
  localparam logic [7:0] OFS_DLYSEL  = 8'h10;
  localparam logic [7:0] OFS_DLYRD   = 8'h14;
  localparam logic [7:0] OFS_CMD     = 8'h18;
  localparam logic [7:0] OFS_ERR     = 8'h1c;
  localparam logic [7:0] OFS_SPOLL   = 8'h20;
  localparam logic [7:0] OFS_MSG     = 8'h24;
  localparam logic [7:0] OFS_MODEL   = 8'h28;
  localparam logic [7:0] OFS_TEST    = 8'h2c;
  localparam logic [7:0] OFS_IRQSTAT = 8'h30;
  localparam logic [7:0] OFS_IRQMASK = 8'h34;
  // Field positions
  localparam int CH_LSB      = 16;
  localparam int SPOLL_ERR   = 5;
  localparam int MSG_POS_LSB = 8;
  localparam int IRQ_ERR     = 0;
  localparam int IRQ_SETTLED = 1;
  localparam int IRQ_W       = 2;
  // Delay timing and message length
  localparam int CLK_NS       = 100;
  localparam int STEP_MS      = 4;
  localparam int TICK_CYC     = STEP_MS * 1000000 / CLK_NS;
  localparam int DLY_MAX_MS   = 32000;
  localparam int DLY_RST_MS   = 20;
  localparam int DLY_RST_STEP = DLY_RST_MS / STEP_MS;
  localparam int STEP_W       = 13;
  localparam int MSG_LEN      = 12;
  // Reset values
  localparam logic       DISPLAY_RST = 1'b1;
  localparam logic [1:0] PWRUP_RST   = 2'h0;
  // Error codes
  localparam logic [4:0] ERR_NONE  = 5'h00;
  localparam logic [4:0] ERR_RANGE = 5'h05;
  localparam logic [4:0] ERR_LEN   = 5'h07;
  localparam logic [4:0] ERR_CAL   = 5'h10;
  // Commands written to the command register
  typedef enum logic [2:0] {
    OP_VOLTAGE_PROGRAM, OP_CURRENT_LIMIT_PROGRAM, OP_STATE_RECALL,
    OP_OVERVOLTAGE_CLEAR, OP_OVERCURRENT_CLEAR, OP_OUT_ON, OP_OUT_OFF, OP_CAL
  } rpd_op_t;
endpackage : rpd_pkg

// File: hdl/rpd_timer.sv
// Purpose: One output's reprogramming delay countdown
// Assumes: tick is a one-cycle pulse every delay step
// Notes:   Tick phase is free running, so a delay may end up to a step early
`timescale 1ns/100ps
module rpd_timer #(
  parameter int STEP_W = 13
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              tick,
  input  wire logic              start,
  input  wire logic [STEP_W-1:0] setting,
  output logic                   busy
);
  logic [STEP_W-1:0] count_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= '0;
    end else if (start) begin
      count_r <= setting;
    end else if (tick && count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  assign busy = (count_r != '0);
endmodule : rpd_timer

// File: hdl/rpd_core.sv
// Purpose: Reprogramming delay, error latch, display and query registers
// Assumes: AHB-Lite slave with zero wait states, single word transfers
// Notes:   Reads answer at once, so a read after a write sees the old value
//
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module rpd_core #(
  parameter int          N_OUT    = 4,
  parameter int          TICK_CYC = rpd_pkg::TICK_CYC,
  parameter logic [15:0] MODEL    = 16'h1234 // Arbitrary value
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire logic [4*N_OUT-1:0]   stat_raw,
  output logic [4*N_OUT-1:0]        stat_gated,
  output logic [N_OUT-1:0]          dly_busy,
  input  wire logic                 hw_err_pulse,
  input  wire logic [4:0]           hw_err_code,
  input  wire logic [4:0]           selftest_code,
  output logic                      selftest_start,
  input  wire logic [1:0]           pwrup_nv,
  output logic [1:0]                pwrup_state,
  output logic [N_OUT-1:0]          out_enable,
  output logic                      out_cc_off,
  output logic                      display_on,
  output logic [8*12-1:0]           msg_text,
  output logic                      cal_enable,
  output logic                      cal_strobe,
  output logic                      err_led,
  output logic                      irq
);
  localparam int CW = $clog2(N_OUT) > 0 ? $clog2(N_OUT) : 1;
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);

  function automatic logic [rpd_pkg::STEP_W-1:0] to_steps(input logic [15:0] ms);
    logic [16:0] sum;
    sum = {1'b0, ms} + 17'h00002;
    to_steps = sum[rpd_pkg::STEP_W+1:2];
  endfunction : to_steps

  function automatic logic [7:0] show_char(input logic [7:0] c);
    if ((c >= 8'h41 && c <= 8'h5a) || (c >= 8'h30 && c <= 8'h39) || c == 8'h20) begin
      show_char = c;
    end else begin
      show_char = 8'h20;
    end
  endfunction : show_char

  // Bus address phase capture
  logic            rd_go;
  logic            wr_pend_r;
  logic [7:0]      wr_ofs_r;
  logic [7:0]      rd_ofs;
  logic [31:0]     rd_val;
  logic            wr_go;

  assign rd_ofs    = haddr[7:0];
  assign rd_go     = hsel && hready && htrans[1] && !hwrite;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r  <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      wr_ofs_r  <= haddr[7:0];
    end
  end

  function automatic logic wr_to(input logic pend, input logic [7:0] a, input logic [7:0] o);
    wr_to = pend && (a == o);
  endfunction : wr_to

  assign wr_go = wr_pend_r;

  // Decoded write fields
  logic [CW-1:0]   wr_ch;
  logic [15:0]     wr_ms;
  rpd_pkg::rpd_op_t wr_op;
  logic            ch_ok;
  logic            dly_wr;
  logic            range_err;
  logic            cmd_wr;
  logic            cal_err;
  logic            msg_wr;
  logic            len_err;

  assign wr_ch     = hwdata[rpd_pkg::CH_LSB +: CW];
  assign ch_ok     = (32'(wr_ch) < N_OUT);
  assign wr_ms     = hwdata[15:0];
  assign wr_op     = rpd_pkg::rpd_op_t'(hwdata[2:0]);
  assign dly_wr    = wr_to(wr_go, wr_ofs_r, rpd_pkg::OFS_DLYSET);
  assign range_err = dly_wr && (32'(wr_ms) > rpd_pkg::DLY_MAX_MS);
  assign cmd_wr    = wr_to(wr_go, wr_ofs_r, rpd_pkg::OFS_CMD) && ch_ok;
  assign cal_err   = wr_to(wr_go, wr_ofs_r, rpd_pkg::OFS_CMD)
                     && wr_op == rpd_pkg::OP_CAL && !cal_enable;
  assign msg_wr    = wr_to(wr_go, wr_ofs_r, rpd_pkg::OFS_MSG);
  assign len_err   = msg_wr && (hwdata[rpd_pkg::MSG_POS_LSB +: 4] >= 4'(rpd_pkg::MSG_LEN));

  // Delay settings, one per output
  logic [rpd_pkg::STEP_W-1:0] dly_r [N_OUT];
  logic [CW-1:0]              dly_sel_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < N_OUT; i++) begin
        dly_r[i] <= rpd_pkg::STEP_W'(rpd_pkg::DLY_RST_STEP);
      end
    end else if (dly_wr && !range_err && ch_ok) begin
      dly_r[wr_ch] <= to_steps(wr_ms);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly_sel_r <= '0;
    end else if (wr_to(wr_go, wr_ofs_r, rpd_pkg::OFS_DLYSEL)) begin
      dly_sel_r <= hwdata[CW-1:0];
    end
  end

  // Step tick; a long count, so shortened by parameter in simulation
  logic [15:0] pre_r;
  logic        tick;

  assign tick = (pre_r == TICK_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= 16'h0000;
    end else if (tick) begin
      pre_r <= 16'h0000;
    end else begin
      pre_r <= pre_r + 16'h0001;
    end
  end

  // Per-output delay timers and status masking
  logic [N_OUT-1:0] dly_start;
  logic [N_OUT-1:0] busy_d_r;

  for (genvar g = 0; g < N_OUT; g++) begin : g_out
    assign dly_start[g] = cmd_wr && wr_op != rpd_pkg::OP_CAL && 32'(wr_ch) == g;
    rpd_timer #(
      .STEP_W  (rpd_pkg::STEP_W)
    ) u_timer (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tick    (tick),
      .start   (dly_start[g]),
      .setting (dly_r[g]),
      .busy    (dly_busy[g])
    );
    assign stat_gated[4*g +: 4] = dly_busy[g] ? 4'h0 : stat_raw[4*g +: 4];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_d_r <= '0;
    end else begin
      busy_d_r <= dly_busy;
    end
  end

  // Power-up state: the stored choice is caught just after reset release
  logic init_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_r <= 1'b0;
    end else begin
      init_r <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwrup_state <= rpd_pkg::PWRUP_RST;
    end else if (!init_r) begin
      pwrup_state <= pwrup_nv;
    end else if (wr_to(wr_go, wr_ofs_r, rpd_pkg::OFS_PWRUP)) begin
      pwrup_state <= hwdata[1:0];
    end
  end

  assign out_cc_off = pwrup_state[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_enable <= '0;
    end else if (!init_r) begin
      out_enable <= (pwrup_nv == 2'h1 || pwrup_nv == 2'h2) ? '1 : '0;
    end else if (cmd_wr && wr_op == rpd_pkg::OP_OUT_ON) begin
      out_enable[wr_ch] <= 1'b1;
    end else if (cmd_wr && wr_op == rpd_pkg::OP_OUT_OFF) begin
      out_enable[wr_ch] <= 1'b0;
    end
  end

  // Display and message
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      display_on <= rpd_pkg::DISPLAY_RST;
    end else if (wr_to(wr_go, wr_ofs_r, rpd_pkg::OFS_DISPLAY)) begin
      display_on <= hwdata[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msg_text <= {rpd_pkg::MSG_LEN{8'h20}};
    end else if (msg_wr && !len_err) begin
      msg_text[8*hwdata[rpd_pkg::MSG_POS_LSB +: 4] +: 8] <= show_char(hwdata[7:0]);
    end
  end

  // Calibration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_enable <= 1'b0;
    end else if (wr_to(wr_go, wr_ofs_r, rpd_pkg::OFS_CALMODE)) begin
      cal_enable <= hwdata[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_strobe <= 1'b0;
    end else begin
      cal_strobe <= cmd_wr && wr_op == rpd_pkg::OP_CAL && cal_enable;
    end
  end

  // Error latch; a new error wins over a clearing query in the same cycle
  logic       err_set;
  logic [4:0] err_new;
  logic       err_clr;
  logic [4:0] err_code_r;

  assign err_set = hw_err_pulse || range_err || len_err || cal_err;
  assign err_clr = rd_go && rd_ofs == rpd_pkg::OFS_ERR;

  always_comb begin
    if (hw_err_pulse) begin
      err_new = hw_err_code;
    end else if (range_err) begin
      err_new = rpd_pkg::ERR_RANGE;
    end else if (len_err) begin
      err_new = rpd_pkg::ERR_LEN;
    end else begin
      err_new = rpd_pkg::ERR_CAL;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_led    <= 1'b0;
      err_code_r <= rpd_pkg::ERR_NONE;
    end else if (err_set) begin
      err_led    <= 1'b1;
      err_code_r <= err_new;
    end else if (err_clr) begin
      err_led    <= 1'b0;
      err_code_r <= rpd_pkg::ERR_NONE;
    end
  end

  // Self-test only touches the digital side; outputs stay as they are
  assign selftest_start = rd_go && rd_ofs == rpd_pkg::OFS_TEST;

  // Interrupts: sticky, cleared by reading the status register
  logic [rpd_pkg::IRQ_W-1:0] irq_ev;
  logic [rpd_pkg::IRQ_W-1:0] irq_stat_r;
  logic [rpd_pkg::IRQ_W-1:0] irq_mask_r;
  logic                      irq_rd;

  assign irq_ev[rpd_pkg::IRQ_ERR]     = err_set;
  assign irq_ev[rpd_pkg::IRQ_SETTLED] = |(busy_d_r & ~dly_busy);
  assign irq_rd = rd_go && rd_ofs == rpd_pkg::OFS_IRQSTAT;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_rd ? '0 : irq_stat_r) | irq_ev;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_r <= '0;
    end else if (wr_to(wr_go, wr_ofs_r, rpd_pkg::OFS_IRQMASK)) begin
      irq_mask_r <= hwdata[rpd_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // Read mux; answers are taken at the address phase so data is ready at once
  always_comb begin
    rd_val = 32'h0000_0000;
    case (rd_ofs)
      rpd_pkg::OFS_DISPLAY: rd_val[0]   = display_on;
      rpd_pkg::OFS_CALMODE: rd_val[0]   = cal_enable;
      rpd_pkg::OFS_PWRUP:   rd_val[1:0] = pwrup_state;
      rpd_pkg::OFS_DLYSEL:  rd_val[CW-1:0] = dly_sel_r;
      rpd_pkg::OFS_DLYRD:   rd_val[15:0] = 16'({dly_r[dly_sel_r], 2'b00});
      rpd_pkg::OFS_ERR:     rd_val[4:0] = err_code_r;
      rpd_pkg::OFS_SPOLL:   rd_val[rpd_pkg::SPOLL_ERR] = err_led;
      rpd_pkg::OFS_MODEL:   rd_val[15:0] = MODEL;
      rpd_pkg::OFS_TEST:    rd_val[4:0] = selftest_code;
      rpd_pkg::OFS_IRQSTAT: rd_val[rpd_pkg::IRQ_W-1:0] = irq_stat_r;
      rpd_pkg::OFS_IRQMASK: rd_val[rpd_pkg::IRQ_W-1:0] = irq_mask_r;
      default:              rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_go) begin
      hrdata <= rd_val;
    end
  end

  // Checks
  sequence s_dly_cmd0;
    cmd_wr && wr_op == rpd_pkg::OP_VOLTAGE_PROGRAM && wr_ch == '0 && dly_r[0] != '0;
  endsequence

  sequence s_err_query;
    err_clr && !err_set;
  endsequence

  mask_busy_a: assert property (@(posedge hclk) disable iff (!hresetn)
    dly_busy[0] |-> stat_gated[3:0] == 4'h0) else $error("status passed during delay");
  dly_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_dly_cmd0 |=> dly_busy[0]) else $error("delay not started");
  dly_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(init_r) |-> dly_r[0] == 13'h0005) else $error("delay reset not 20 ms");
  dly_round_a: assert property (@(posedge hclk) disable iff (!hresetn)
    dly_wr && !range_err && wr_ch == '0 |=> dly_r[0] == to_steps($past(wr_ms)))
    else $error("delay not rounded");
  range_err_a: assert property (@(posedge hclk) disable iff (!hresetn)
    range_err && !hw_err_pulse |=> err_led && err_code_r == 5'h05 && $stable(dly_r[0]))
    else $error("range error not flagged");
  err_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_err_query ##1 !err_set |-> !err_led ##1 err_code_r == 5'h00 || err_set)
    else $error("error not cleared");
  cal_refuse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cal_err |=> !cal_strobe && err_led) else $error("calibration not refused");
  display_ctl_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_to(wr_go, wr_ofs_r, rpd_pkg::OFS_DISPLAY) |=> display_on == $past(hwdata[0]))
    else $error("display state wrong");
  poll_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_go && rd_ofs == rpd_pkg::OFS_SPOLL |=> hrdata[5] == $past(err_led))
    else $error("poll bit 5 wrong");
endmodule : rpd_core

// File: testbench/rpd_host_model.sv
// Purpose: AHB-Lite master standing in for the remote controller
// Assumes: Single word transfers, the slave always answers OKAY
// Notes:   Released write data is inverted so stale values never look valid
`timescale 1ns/100ps
module rpd_host_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end
  // Bounded so a dead slave cannot hang the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
  endtask : wait_rdy
  // A query is always sent first, its answer taken in the data phase after
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    hwdata <= ~d;
    #1;
  endtask : xfer
endmodule : rpd_host_model

// File: testbench/reprog_delay_and_status_queries_tb_top.sv
// Purpose: Self-checking bench for the reprogramming delay and query block
// Assumes: Delay tick shortened to a few cycles, host model on the bus
// Notes:   Delay length is judged with a step of slack for the free tick
`timescale 1ns/100ps
module reprog_delay_and_status_queries_tb_top;
  localparam int TCYC = 4;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp, selftest_start, out_cc_off;
  logic        display_on, cal_enable, cal_strobe, err_led, irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans, pwrup_state;
  logic [2:0]  hsize;
  logic [15:0] stat_raw = 16'hffff;
  logic [15:0] stat_gated;
  logic [3:0]  dly_busy, out_enable, oe;
  logic        hw_err_pulse = 1'b0;
  logic [4:0]  hw_err_code = 5'h0a;
  logic [4:0]  selftest_code = 5'h14;
  logic [1:0]  pwrup_nv = 2'h2;
  logic [95:0] msg_text;
  int          fail_count = 0;
  int          tests_run = 0;
  int          cal_cnt = 0;
  int          st_cnt = 0;

  // Model value is arbitrary
  rpd_core #(.N_OUT(4), .TICK_CYC(TCYC), .MODEL(16'h0abc)) u_rpd_core (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .stat_raw, .stat_gated,
    .dly_busy, .hw_err_pulse, .hw_err_code, .selftest_code, .selftest_start,
    .pwrup_nv, .pwrup_state, .out_enable, .out_cc_off, .display_on, .msg_text,
    .cal_enable, .cal_strobe, .err_led, .irq);
  rpd_host_model u_rpd_host_model (.hclk, .hready(hreadyout), .hrdata, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata);

  always #50 hclk = ~hclk;
  always @(posedge hclk) begin
    if (cal_strobe === 1'b1) cal_cnt <= cal_cnt + 1;
    if (selftest_start === 1'b1) st_cnt <= st_cnt + 1;
  end

  task automatic chk(input string n, input logic [95:0] s, input logic [95:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_rpd_host_model.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    u_rpd_host_model.xfer(1'b0, a, 32'h0, q);
    chk(n, q, e);
  endtask : rdc

  task automatic t_reset();
    chk("disp_rst", display_on, 1'b1);
    chk("cal_rst", cal_enable, 1'b0);
    chk("out_en", out_enable, 4'hf);
    chk("cc_off", out_cc_off, 1'b1);
    chk("pwrup", pwrup_state, 2'h2);
    wr(rpd_pkg::OFS_DLYSEL, 32'h3);
    rdc("dly_rst", rpd_pkg::OFS_DLYRD, 32'd20);
    for (int v = 0; v < 4; v++) begin
      wr(rpd_pkg::OFS_PWRUP, v);
      rdc("pwrup_q", rpd_pkg::OFS_PWRUP, v);
      chk("cc_mode", out_cc_off, v[1]);
    end
  endtask : t_reset

  task automatic t_mask();
    int n;
    wr(rpd_pkg::OFS_DLYSET, {16'h2, 16'd8});
    u_rpd_host_model.xfer(1'b0, rpd_pkg::OFS_IRQSTAT, 32'h0, q);
    for (int op = 0; op < 7; op++) begin
      wr(rpd_pkg::OFS_IRQMASK, {30'h0, op[0], 1'b0});
      wr(rpd_pkg::OFS_CMD, {14'h0, 2'h2, 13'h0, op[2:0]});
      chk("busy", dly_busy, 4'h4);
      chk("gated", stat_gated, 16'hf0ff);
      n = 0;
      while (dly_busy[2] !== 1'b0 && n < 40) begin
        @(posedge hclk);
        #1;
        n++;
      end
      chk("len", 32'(n >= TCYC - 2 && n <= 2 * TCYC + 1), 32'h1);
      chk("open", stat_gated, 16'hffff);
      // The settled event lands in the status register one edge later
      @(posedge hclk);
      #1;
      chk("irq", irq, op[0]);
      rdc("irq_st", rpd_pkg::OFS_IRQSTAT, 32'h2);
      chk("irq_clr", irq, 1'b0);
    end
  endtask : t_mask

  task automatic t_delay();
    wr(rpd_pkg::OFS_DLYSET, {16'h1, 16'd10});
    wr(rpd_pkg::OFS_DLYSEL, 32'h1);
    rdc("round", rpd_pkg::OFS_DLYRD, 32'd12);
    wr(rpd_pkg::OFS_DLYSET, {16'h1, 16'd32000});
    rdc("max", rpd_pkg::OFS_DLYRD, 32'd32000);
    wr(rpd_pkg::OFS_DLYSET, {16'h1, 16'd32001});
    rdc("keep", rpd_pkg::OFS_DLYRD, 32'd32000);
    chk("led", err_led, 1'b1);
    rdc("poll", rpd_pkg::OFS_SPOLL, 32'h20);
    rdc("code", rpd_pkg::OFS_ERR, 32'h5);
    rdc("code_clr", rpd_pkg::OFS_ERR, 32'h0);
    rdc("poll_clr", rpd_pkg::OFS_SPOLL, 32'h0);
    chk("led_off", err_led, 1'b0);
    wr(rpd_pkg::OFS_DLYSET, {16'h1, 16'd0});
    rdc("zero", rpd_pkg::OFS_DLYRD, 32'h0);
  endtask : t_delay

  task automatic t_display();
    for (int v = 0; v < 2; v++) begin
      wr(rpd_pkg::OFS_DISPLAY, v);
      chk("dsp", display_on, v[0]);
      rdc("dsp_q", rpd_pkg::OFS_DISPLAY, v);
    end
    wr(rpd_pkg::OFS_MSG, 32'h0041);
    wr(rpd_pkg::OFS_MSG, 32'h0b61);
    wr(rpd_pkg::OFS_MSG, 32'h0a37);
    wr(rpd_pkg::OFS_MSG, 32'h0c42);
    chk("msg", msg_text, {8'h20, 8'h37, {9{8'h20}}, 8'h41});
    rdc("len_err", rpd_pkg::OFS_ERR, 32'h7);
  endtask : t_display

  task automatic t_query();
    oe = out_enable;
    rdc("model", rpd_pkg::OFS_MODEL, 32'h0abc);
    rdc("test", rpd_pkg::OFS_TEST, 32'h14);
    chk("st_pulse", st_cnt, 32'h1);
    chk("out_keep", out_enable, oe);
    chk("gate_keep", stat_gated, 16'hffff);
    rdc("unmap", 8'h3c, 32'h0);
  endtask : t_query

  task automatic t_cal();
    wr(rpd_pkg::OFS_CMD, 32'h0);
    chk("busy0", dly_busy, 4'h1);
    wr(rpd_pkg::OFS_CMD, 32'h7);
    rdc("cal_err", rpd_pkg::OFS_ERR, 32'h10);
    chk("no_strb", cal_cnt, 32'h0);
    wr(rpd_pkg::OFS_CALMODE, 32'h1);
    rdc("cal_q", rpd_pkg::OFS_CALMODE, 32'h1);
    wr(rpd_pkg::OFS_CMD, 32'h7);
    @(posedge hclk);
    #1;
    chk("strb", cal_cnt, 32'h1);
    rdc("cal_ok", rpd_pkg::OFS_ERR, 32'h0);
  endtask : t_cal

  task automatic t_hwerr();
    u_rpd_host_model.xfer(1'b0, rpd_pkg::OFS_IRQSTAT, 32'h0, q);
    wr(rpd_pkg::OFS_IRQMASK, 32'h1);
    chk("irq_idle", irq, 1'b0);
    @(posedge hclk);
    hw_err_pulse <= 1'b1;
    @(posedge hclk);
    hw_err_pulse <= 1'b0;
    #1;
    chk("hw_led", err_led, 1'b1);
    chk("irq_err", irq, 1'b1);
    rdc("hw_code", rpd_pkg::OFS_ERR, 32'h0a);
    rdc("irq_st", rpd_pkg::OFS_IRQSTAT, 32'h1);
    chk("irq_off", irq, 1'b0);
  endtask : t_hwerr

  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    #1;
    t_reset();
    t_mask();
    t_delay();
    t_display();
    t_query();
    t_cal();
    t_hwerr();
    wrap_up();
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    #(100 * 20000);
    fail_count++;
    wrap_up();
  end
endmodule : reprog_delay_and_status_queries_tb_top
